/* core/pin_level_port_defines.svh */
// Offsets, field positions, reset values and masks of the port block
`ifndef PIN_LEVEL_PORT_DEFINES_SVH
`define PIN_LEVEL_PORT_DEFINES_SVH
`define ADDR_W          8
`define OFF_PORT        8'h00
`define OFF_LAT         8'h04
`define OFF_TRIS        8'h08
`define OFF_ICM         8'h0C
`define OFF_ICE         8'h10
`define OFF_ICX         8'h14
`define OFF_ADC         8'h18
`define OFF_CFG         8'h1C
`define OFF_CTL         8'h20
`define MASK_ICM        8'hFF
`define MASK_ICE        8'hF5
`define MASK_ICX        8'hDB
`define MASK_ADC        8'h3F
`define MASK_CTL        8'h01
`define RST_LAT         8'h00
`define RST_TRIS        8'hFF
`define RST_ICM         8'h00
`define RST_ICE         8'hF5
`define RST_ICX         8'h00
`define RST_CTL         8'h00
`define RST_ADC_ANALOG  8'h00
`define RST_ADC_DIGITAL 8'h07
`define PCFG_BASE       5'h0E
`define BIT_FLAG        0
`define BIT_IE          3
`define BIT_PRIO        0
`define BIT_PUDN        7
`define BIT_EDGE0       6
`define BIT_EDGE2       4
`define BIT_FAULT_EN    0
`define CH_PIN0         4'hC
`define CH_PIN1         4'hA
`define CH_PIN2         4'h8
`define CH_PIN3         4'h9
`define CH_PIN4         4'hB
`define PIN_CAP2        3
`define PIN_PGM         5
`define PIN_PGC         6
`define PIN_PGD         7
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

/* core/pin_level_port_pkg.sv */
// Types shared by the port block
package pin_level_port_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0]
  {
    BOOT_SYNC0 = 2'b00,
    BOOT_SYNC1 = 2'b01,
    BOOT_SYNC2 = 2'b11,
    BOOT_DONE  = 2'b10
  } boot_state_t;
endpackage

/* core/pin_sync.sv */
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module pin_sync
#(
  parameter int W = 8
)
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      q_o    <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

/* core/axil_slave.sv */
// AXI4-Lite slave front end producing register read and write strobes
`timescale 1ns/1ps
`include "pin_level_port_defines.svh"
module axil_slave
  import pin_level_port_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic [`ADDR_W-1:0] awaddr_i,
  input  wire logic               awvalid_i,
  output logic                    awready_o,
  input  wire logic [31:0]        wdata_i,
  input  wire logic [3:0]         wstrb_i,
  input  wire logic               wvalid_i,
  output logic                    wready_o,
  output logic [1:0]              bresp_o,
  output logic                    bvalid_o,
  input  wire logic               bready_i,
  input  wire logic [`ADDR_W-1:0] araddr_i,
  input  wire logic               arvalid_i,
  output logic                    arready_o,
  output logic [31:0]             rdata_o,
  output logic [1:0]              rresp_o,
  output logic                    rvalid_o,
  input  wire logic               rready_i,
  output logic                    wr_o,
  output logic [`ADDR_W-1:0]      wr_addr_o,
  output byte_t                   wr_data_o,
  input  wire logic               wr_err_i,
  output logic                    rd_o,
  output logic [`ADDR_W-1:0]      rd_addr_o,
  input  wire byte_t              rd_data_i,
  input  wire logic               rd_err_i
);
  logic               aw_q, aw_d, w_q, w_d, bv_d, rv_d;
  logic [`ADDR_W-1:0] awa_q, awa_d;
  byte_t              wd_q, wd_d;
  logic               lane_q, lane_d;
  logic [1:0]         br_d, rr_d;
  logic [31:0]        rdat_d;

  assign awready_o = ~aw_q & ~bvalid_o;
  assign wready_o  = ~w_q & ~bvalid_o;
  assign arready_o = ~rvalid_o;
  // Write fires once both halves are held; lane 0 gates the byte
  assign wr_o      = aw_q & w_q & ~bvalid_o & lane_q;
  assign wr_addr_o = awa_q;
  assign wr_data_o = wd_q;
  assign rd_o      = arvalid_i & arready_o;
  assign rd_addr_o = araddr_i;

  always_comb
  begin
    aw_d   = aw_q;
    w_d    = w_q;
    awa_d  = awa_q;
    wd_d   = wd_q;
    lane_d = lane_q;
    bv_d   = bvalid_o;
    br_d   = bresp_o;
    rv_d   = rvalid_o;
    rr_d   = rresp_o;
    rdat_d = rdata_o;
    if (awvalid_i && awready_o)
    begin
      aw_d  = 1'b1;
      awa_d = awaddr_i;
    end
    if (wvalid_i && wready_o)
    begin
      w_d    = 1'b1;
      wd_d   = wdata_i[7:0];
      lane_d = wstrb_i[0];
    end
    if (aw_q && w_q && !bvalid_o)
    begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = wr_err_i ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (bvalid_o && bready_i)
      bv_d = 1'b0;
    if (rd_o)
    begin
      rv_d   = 1'b1;
      rr_d   = rd_err_i ? `RESP_SLVERR : `RESP_OKAY;
      rdat_d = {24'h00_0000, rd_data_i};
    end
    else if (rvalid_o && rready_i)
      rv_d = 1'b0;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awa_q    <= '0;
      wd_q     <= '0;
      lane_q   <= 1'b0;
      bvalid_o <= 1'b0;
      bresp_o  <= `RESP_OKAY;
      rvalid_o <= 1'b0;
      rresp_o  <= `RESP_OKAY;
      rdata_o  <= 32'h0000_0000;
    end
    else
    begin
      aw_q     <= aw_d;
      w_q      <= w_d;
      awa_q    <= awa_d;
      wd_q     <= wd_d;
      lane_q   <= lane_d;
      bvalid_o <= bv_d;
      bresp_o  <= br_d;
      rvalid_o <= rv_d;
      rresp_o  <= rr_d;
      rdata_o  <= rdat_d;
    end
  end
endmodule

/* core/port_b.sv */
// Eight-bit general-purpose port with pin multiplexing and change detect
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pin_level_port_defines.svh"
module port_b
  import pin_level_port_pkg::*;
(
  input  wire logic               MCLK_I,
  input  wire logic               RESET_I,
  input  wire logic [`ADDR_W-1:0] AWADDR_I,
  input  wire logic               AWVALID_I,
  output logic                    AWREADY_O,
  input  wire logic [31:0]        WDATA_I,
  input  wire logic [3:0]         WSTRB_I,
  input  wire logic               WVALID_I,
  output logic                    WREADY_O,
  output logic [1:0]              BRESP_O,
  output logic                    BVALID_O,
  input  wire logic               BREADY_I,
  input  wire logic [`ADDR_W-1:0] ARADDR_I,
  input  wire logic               ARVALID_I,
  output logic                    ARREADY_O,
  output logic [31:0]             RDATA_O,
  output logic [1:0]              RRESP_O,
  output logic                    RVALID_O,
  input  wire logic               RREADY_I,
  input  wire logic [7:0]         PIN_I,
  output logic      [7:0]         PIN_O,
  output logic      [7:0]         PIN_OE_N_O,
  output logic      [7:0]         PULLUP_EN_O,
  output logic      [4:0]         ANALOG_SEL_O,
  input  wire logic               ANALOG_DEFAULT_CFG_I,
  input  wire logic               LOW_VOLT_PROG_CFG_I,
  input  wire logic               CAPTURE2_PIN_SELECT_CFG_I,
  input  wire logic               DEBUG_EN_I,
  input  wire logic               PROG_DATA_OUT_I,
  input  wire logic               PROG_DATA_DRIVE_I,
  output logic                    PROG_DATA_IN_O,
  output logic                    PROG_CLOCK_IN_O,
  output logic                    PROG_MODE_ENTRY_IN_O,
  input  wire logic               CAPTURE2_OUT_I,
  input  wire logic               CAPTURE2_OUT_EN_I,
  output logic                    CAPTURE2_IN_O,
  output logic [2:0]              EXT_IRQ_IN_O,
  output logic [2:0]              EXT_IRQ_EDGE_SEL_O,
  output logic                    PWM_FAULT_IN_O,
  output logic                    CHANGE_IRQ_O,
  output logic                    CHANGE_IRQ_PRIORITY_O
);
  byte_t              lat_q, lat_d, tris_q, tris_d;
  byte_t              icm_q, icm_d, ice_q, ice_d;
  byte_t              icx_q, icx_d, adc_q, adc_d, ctl_q, ctl_d;
  logic [3:0]         last_q, last_d;
  boot_state_t        boot_q, boot_d;
  logic [7:0]         pin_s;
  logic [2:0]         cfg_s;
  logic               wr, rd, wr_err, rd_err;
  logic [`ADDR_W-1:0] wr_addr, rd_addr;
  byte_t              wr_data, rd_data, port_val;
  logic [4:0]         analog;
  logic [7:0]         override, din, pu_on;
  logic               mismatch, low_volt_prog_cfg, cap2_here;

  // Analog channel n is active while the config field is at most base - n
  function automatic logic is_analog(input logic [3:0] field,
                                     input logic [3:0] ch);
    is_analog = ({1'b0, field} <= (`PCFG_BASE - {1'b0, ch}));
  endfunction

  function automatic logic is_mapped(input logic [`ADDR_W-1:0] a);
    case (a)
      `OFF_PORT, `OFF_LAT, `OFF_TRIS, `OFF_ICM, `OFF_ICE,
      `OFF_ICX, `OFF_ADC, `OFF_CFG, `OFF_CTL: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  pin_sync
  #(
    .W (8)
  )
  u_pin_sync
  (
    .clk_i (MCLK_I),
    .rst_i (RESET_I),
    .d_i   (PIN_I),
    .q_o   (pin_s)
  );

  pin_sync
  #(
    .W (3)
  )
  u_cfg_sync
  (
    .clk_i (MCLK_I),
    .rst_i (RESET_I),
    .d_i   ({CAPTURE2_PIN_SELECT_CFG_I, LOW_VOLT_PROG_CFG_I,
             ANALOG_DEFAULT_CFG_I}),
    .q_o   (cfg_s)
  );

  axil_slave u_bus
  (
    .clk_i     (MCLK_I),
    .rst_i     (RESET_I),
    .awaddr_i  (AWADDR_I),
    .awvalid_i (AWVALID_I),
    .awready_o (AWREADY_O),
    .wdata_i   (WDATA_I),
    .wstrb_i   (WSTRB_I),
    .wvalid_i  (WVALID_I),
    .wready_o  (WREADY_O),
    .bresp_o   (BRESP_O),
    .bvalid_o  (BVALID_O),
    .bready_i  (BREADY_I),
    .araddr_i  (ARADDR_I),
    .arvalid_i (ARVALID_I),
    .arready_o (ARREADY_O),
    .rdata_o   (RDATA_O),
    .rresp_o   (RRESP_O),
    .rvalid_o  (RVALID_O),
    .rready_i  (RREADY_I),
    .wr_o      (wr),
    .wr_addr_o (wr_addr),
    .wr_data_o (wr_data),
    .wr_err_i  (wr_err),
    .rd_o      (rd),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data),
    .rd_err_i  (rd_err)
  );

  assign wr_err = ~is_mapped(wr_addr);
  assign rd_err = ~is_mapped(rd_addr);

  // Straps are only trusted once boot has passed both sync stages
  assign low_volt_prog_cfg       = cfg_s[1] & (boot_q == BOOT_DONE);
  assign cap2_here = ~cfg_s[2] & (boot_q == BOOT_DONE);

  // Lower pins follow the converter field; upper pins are always digital
  always_comb
  begin
    analog[0] = is_analog(adc_q[3:0], `CH_PIN0);
    analog[1] = is_analog(adc_q[3:0], `CH_PIN1);
    analog[2] = is_analog(adc_q[3:0], `CH_PIN2);
    analog[3] = is_analog(adc_q[3:0], `CH_PIN3);
    analog[4] = is_analog(adc_q[3:0], `CH_PIN4);
  end

  // A claimed pin keeps only its programming role
  always_comb
  begin
    override = 8'h00;
    override[`PIN_PGM] = low_volt_prog_cfg;
    override[`PIN_PGC] = DEBUG_EN_I;
    override[`PIN_PGD] = DEBUG_EN_I;
  end

  always_comb
  begin
    din = pin_s & ~override;
    din[4:0] = pin_s[4:0] & ~analog;
    port_val = din;
    port_val[4:0] = din[4:0] & ~analog;
  end

  always_comb
  begin
    // Output path ignores analog selection on the lower pins
    PIN_O      = lat_q;
    PIN_OE_N_O = tris_q | override;
    if (cap2_here && CAPTURE2_OUT_EN_I && !tris_q[`PIN_CAP2])
      PIN_O[`PIN_CAP2] = CAPTURE2_OUT_I;
    PIN_O[`PIN_PGD]      = DEBUG_EN_I ? PROG_DATA_OUT_I : lat_q[`PIN_PGD];
    PIN_OE_N_O[`PIN_PGD] = DEBUG_EN_I ? ~PROG_DATA_DRIVE_I
                                      : tris_q[`PIN_PGD];
    // Outputs and claimed pins never pull up
    pu_on = {8{~ice_q[`BIT_PUDN]}} & tris_q & ~override;
    mismatch = |((din[7:4] ^ last_q) & tris_q[7:4]
                 & ~override[7:4]);
  end

  assign PULLUP_EN_O           = pu_on;
  assign ANALOG_SEL_O          = analog;
  assign EXT_IRQ_IN_O          = din[2:0];
  assign PWM_FAULT_IN_O        = ctl_q[`BIT_FAULT_EN] & tris_q[0]
                                 & din[0];
  assign EXT_IRQ_EDGE_SEL_O    = ice_q[`BIT_EDGE0:`BIT_EDGE2];
  assign CHANGE_IRQ_O          = icm_q[`BIT_FLAG] & icm_q[`BIT_IE];
  assign CHANGE_IRQ_PRIORITY_O = ice_q[`BIT_PRIO];
  assign PROG_MODE_ENTRY_IN_O  = low_volt_prog_cfg & pin_s[`PIN_PGM];
  assign PROG_CLOCK_IN_O       = DEBUG_EN_I & pin_s[`PIN_PGC];
  assign PROG_DATA_IN_O        = DEBUG_EN_I & pin_s[`PIN_PGD];
  assign CAPTURE2_IN_O         = cap2_here & tris_q[`PIN_CAP2]
                                 & din[`PIN_CAP2];

  always_comb
  begin
    case (rd_addr)
      `OFF_PORT: rd_data = port_val;
      `OFF_LAT:  rd_data = lat_q;
      `OFF_TRIS: rd_data = tris_q;
      `OFF_ICM:  rd_data = icm_q;
      `OFF_ICE:  rd_data = ice_q & `MASK_ICE;
      `OFF_ICX:  rd_data = icx_q & `MASK_ICX;
      `OFF_ADC:  rd_data = adc_q & `MASK_ADC;
      `OFF_CFG:  rd_data = {5'h00, cfg_s};
      `OFF_CTL:  rd_data = ctl_q & `MASK_CTL;
      // Unmapped offsets read as zero and answer with an error
      default:   rd_data = 8'h00;
    endcase
  end

  always_comb
  begin
    lat_d  = lat_q;
    tris_d = tris_q;
    icm_d  = icm_q;
    ice_d  = ice_q;
    icx_d  = icx_q;
    adc_d  = adc_q;
    ctl_d  = ctl_q;
    last_d = last_q;
    boot_d = boot_q;
    case (boot_q)
      BOOT_SYNC0: boot_d = BOOT_SYNC1;
      BOOT_SYNC1: boot_d = BOOT_SYNC2;
      // Strap reaches the second sync stage only at the second edge
      BOOT_SYNC2:
      begin
        boot_d = BOOT_DONE;
        adc_d  = cfg_s[0] ? `RST_ADC_ANALOG : `RST_ADC_DIGITAL;
      end
      BOOT_DONE:  boot_d = BOOT_DONE;
      default:    boot_d = BOOT_SYNC0;
    endcase
    // A port read or write ends the mismatch
    if ((rd && rd_addr == `OFF_PORT) || (wr && wr_addr == `OFF_PORT))
      last_d = din[7:4];
    // The strap view ignores writes; unmapped writes change nothing
    if (wr)
    begin
      case (wr_addr)
        `OFF_PORT: lat_d  = wr_data;
        `OFF_LAT:  lat_d  = wr_data;
        `OFF_TRIS: tris_d = wr_data;
        `OFF_ICM:  icm_d  = wr_data;
        `OFF_ICE:  ice_d  = wr_data & `MASK_ICE;
        `OFF_ICX:  icx_d  = wr_data & `MASK_ICX;
        `OFF_ADC:  adc_d  = wr_data & `MASK_ADC;
        `OFF_CTL:  ctl_d  = wr_data & `MASK_CTL;
        default:   lat_d  = lat_q;
      endcase
    end
    // Set wins over a software clear in the same cycle
    if (mismatch)
      icm_d[`BIT_FLAG] = 1'b1;
  end

  always_ff @(posedge MCLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      lat_q  <= `RST_LAT;
      tris_q <= `RST_TRIS;
      icm_q  <= `RST_ICM;
      ice_q  <= `RST_ICE;
      icx_q  <= `RST_ICX;
      adc_q  <= `RST_ADC_DIGITAL;
      ctl_q  <= `RST_CTL;
      last_q <= 4'h0;
      boot_q <= BOOT_SYNC0;
    end
    else
    begin
      lat_q  <= lat_d;
      tris_q <= tris_d;
      icm_q  <= icm_d;
      ice_q  <= ice_d;
      icx_q  <= icx_d;
      adc_q  <= adc_d;
      ctl_q  <= ctl_d;
      last_q <= last_d;
      boot_q <= boot_d;
    end
  end
endmodule

/* bench/port_b_monitor.sv */
// Checker of pin relations at the port block's top ports
`timescale 1ns/1ps
module port_b_monitor
(
  input wire logic       MCLK_I,
  input wire logic       RESET_I,
  input wire logic [7:0] PIN_I,
  input wire logic [7:0] PIN_O,
  input wire logic [7:0] PIN_OE_N_O,
  input wire logic [7:0] PULLUP_EN_O,
  input wire logic [4:0] ANALOG_SEL_O,
  input wire logic       CAPTURE2_PIN_SELECT_CFG_I,
  input wire logic       DEBUG_EN_I,
  input wire logic       PROG_DATA_OUT_I,
  input wire logic       PROG_DATA_DRIVE_I,
  input wire logic       PROG_DATA_IN_O,
  input wire logic       PROG_CLOCK_IN_O,
  input wire logic       PROG_MODE_ENTRY_IN_O,
  input wire logic       CAPTURE2_OUT_I,
  input wire logic       CAPTURE2_OUT_EN_I,
  input wire logic [2:0] EXT_IRQ_IN_O
);
  // Synced pins and straps are only trusted four edges after reset
  logic [2:0] up_q;
  logic [2:0] up_d;
  always_comb
    up_d = (up_q == 3'h4) ? up_q : up_q + 3'h1;
  always_ff @(posedge MCLK_I or posedge RESET_I)
    if (RESET_I)
      up_q <= 3'h0;
    else
      up_q <= up_d;
  default clocking @(posedge MCLK_I);
  endclocking
  default disable iff (RESET_I);
  sequence dbg_on;
    DEBUG_EN_I [*3] ##0 up_q == 3'h4;
  endsequence
  pull_off_out_a : assert property (
    (PULLUP_EN_O & ~PIN_OE_N_O) == 8'h00)
    else $error("pull-up on a driven pin");
  boot_quiet_a : assert property (
    $fell(RESET_I) |-> PULLUP_EN_O == 8'h00 && PIN_OE_N_O == 8'hff)
    else $error("pins not quiet after reset");
  analog_gate_a : assert property (
    (EXT_IRQ_IN_O & ANALOG_SEL_O[2:0]) == 3'h0)
    else $error("analog pin leaks into digital input");
  irq_route_a : assert property (
    up_q == 3'h4 |->
      EXT_IRQ_IN_O == ($past(PIN_I[2:0], 2) & ~ANALOG_SEL_O[2:0]))
    else $error("interrupt input not routed from its pin");
  prog_clock_a : assert property (
    dbg_on |-> PROG_CLOCK_IN_O == $past(PIN_I[6], 2) &&
      PIN_OE_N_O[6] && !PULLUP_EN_O[6])
    else $error("debug clock pin misrouted");
  debug_data_a : assert property (
    dbg_on |-> PIN_OE_N_O[7] == !PROG_DATA_DRIVE_I &&
      (PIN_OE_N_O[7] || PIN_O[7] == PROG_DATA_OUT_I) &&
      PROG_DATA_IN_O == $past(PIN_I[7], 2))
    else $error("debug data pin misrouted");
  entry_pin_a : assert property (
    PROG_MODE_ENTRY_IN_O |-> PIN_OE_N_O[5] && !PULLUP_EN_O[5])
    else $error("mode entry pin still used otherwise");
  cap2_map_a : assert property (
    up_q == 3'h4 && !CAPTURE2_PIN_SELECT_CFG_I && CAPTURE2_OUT_EN_I &&
      !PIN_OE_N_O[3] |-> PIN_O[3] == CAPTURE2_OUT_I)
    else $error("compare output missing on pin 3");
endmodule
bind port_b port_b_monitor i_mon
(
  .MCLK_I(MCLK_I), .RESET_I(RESET_I), .PIN_I(PIN_I), .PIN_O(PIN_O),
  .PIN_OE_N_O(PIN_OE_N_O), .PULLUP_EN_O(PULLUP_EN_O),
  .ANALOG_SEL_O(ANALOG_SEL_O),
  .CAPTURE2_PIN_SELECT_CFG_I(CAPTURE2_PIN_SELECT_CFG_I),
  .DEBUG_EN_I(DEBUG_EN_I), .PROG_DATA_OUT_I(PROG_DATA_OUT_I),
  .PROG_DATA_DRIVE_I(PROG_DATA_DRIVE_I), .PROG_DATA_IN_O(PROG_DATA_IN_O),
  .PROG_CLOCK_IN_O(PROG_CLOCK_IN_O),
  .PROG_MODE_ENTRY_IN_O(PROG_MODE_ENTRY_IN_O),
  .CAPTURE2_OUT_I(CAPTURE2_OUT_I), .CAPTURE2_OUT_EN_I(CAPTURE2_OUT_EN_I),
  .EXT_IRQ_IN_O(EXT_IRQ_IN_O)
);

/* bench/pin_board.sv */
// Board model: resolves each port pin from all of its drivers
`timescale 1ns/1ps
module pin_board
(
  input  wire logic       clk_i,
  input  wire logic [7:0] dev_val_i,
  input  wire logic [7:0] dev_oe_n_i,
  input  wire logic [7:0] pull_en_i,
  input  wire logic [7:0] ext_val_i,
  input  wire logic [7:0] ext_en_i,
  output logic      [7:0] level_o
);
  // Undriven pins toggle so a stale level never passes for a drive
  logic [7:0] float_q = 8'h55;
  always_ff @(posedge clk_i)
    float_q <= ~float_q;
  always_comb
    for (int i = 0; i < 8; i++)
      if (!dev_oe_n_i[i])
        level_o[i] = dev_val_i[i];
      else if (ext_en_i[i])
        level_o[i] = ext_val_i[i];
      else if (pull_en_i[i])
        level_o[i] = 1'b1;
      else
        level_o[i] = float_q[i];
endmodule

/* bench/tb_port_b.sv */
// Self-checking bench of the port block: bus, pins and straps
`timescale 1ns/1ps
`include "pin_level_port_defines.svh"
module tb_port_b
  import pin_level_port_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        ad_cfg = 1'b1, lvp_cfg = 1'b0, cap_cfg = 1'b0;
  logic        dbg = 1'b0, pd_out = 1'b0, pd_drv = 1'b0;
  logic        c2_out = 1'b0, c2_en = 1'b0;
  byte_t       ext_val = 8'h00, ext_en = 8'h00;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rv;
  byte_t       pin_i, pin_o, oe_n, pu_en, lat, tris, lvl;
  logic [4:0]  an_sel;
  logic [2:0]  irq_in, edg;
  logic        pd_in, pc_in, pm_in, c2_in, flt, chg, prio;
  logic [31:0] rnd = 32'h0000_d8ea;
  int          miscompares = 0;
  int          num_checks = 0;
  byte_t       adr [5] = '{`OFF_ICM, `OFF_ICE, `OFF_ICX, `OFF_ADC, `OFF_CTL};
  byte_t       msk [5] = '{8'hff, 8'hf5, 8'hdb, 8'h3f, 8'h01};

  port_b i_dut
  (
    .MCLK_I(clk), .RESET_I(rst), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
    .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
    .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
    .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr),
    .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
    .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
    .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_N_O(oe_n), .PULLUP_EN_O(pu_en),
    .ANALOG_SEL_O(an_sel), .ANALOG_DEFAULT_CFG_I(ad_cfg),
    .LOW_VOLT_PROG_CFG_I(lvp_cfg), .CAPTURE2_PIN_SELECT_CFG_I(cap_cfg),
    .DEBUG_EN_I(dbg), .PROG_DATA_OUT_I(pd_out),
    .PROG_DATA_DRIVE_I(pd_drv), .PROG_DATA_IN_O(pd_in),
    .PROG_CLOCK_IN_O(pc_in), .PROG_MODE_ENTRY_IN_O(pm_in),
    .CAPTURE2_OUT_I(c2_out), .CAPTURE2_OUT_EN_I(c2_en),
    .CAPTURE2_IN_O(c2_in), .EXT_IRQ_IN_O(irq_in),
    .EXT_IRQ_EDGE_SEL_O(edg), .PWM_FAULT_IN_O(flt),
    .CHANGE_IRQ_O(chg), .CHANGE_IRQ_PRIORITY_O(prio)
  );

  pin_board i_board
  (
    .clk_i(clk), .dev_val_i(pin_o), .dev_oe_n_i(oe_n), .pull_en_i(pu_en),
    .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(pin_i)
  );

  initial
    forever #10 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Pin i is analog while field plus its converter channel stays <= 14
  function automatic logic [4:0] exp_an(input logic [3:0] f);
    logic [3:0] ch [5] = '{4'hc, 4'ha, 4'h8, 4'h9, 4'hb};
    for (int i = 0; i < 5; i++)
      exp_an[i] = (f + ch[i] <= 14);
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input byte_t got, input byte_t exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    miscompares++;
    $display("FAIL at %0t bus wait ran out", $time);
    wrap_up();
  endtask

  task automatic wr(input byte_t a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    logic pa, pw, pb, ka, kw;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    for (int n = 0; n < 40 && pb; n++)
    begin
      @(negedge clk);
      ka = pa & awready;
      kw = pw & wready;
      pb = !bvalid;
      r = bresp;
      @(posedge clk);
      if (ka)
        awvalid <= 1'b0;
      if (kw)
        wvalid <= 1'b0;
      if (!pb)
        bready <= 1'b0;
      pa = pa & ~ka;
      pw = pw & ~kw;
    end
    if (pb)
      hang();
  endtask

  task automatic rd(input byte_t a, output logic [31:0] d,
                    output logic [1:0] r);
    logic pa, pr, ka;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    pa = 1'b1;
    pr = 1'b1;
    for (int n = 0; n < 40 && pr; n++)
    begin
      @(negedge clk);
      ka = pa & arready;
      pr = !rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ka)
        arvalid <= 1'b0;
      if (!pr)
        rready <= 1'b0;
      pa = pa & ~ka;
    end
    if (pr)
      hang();
  endtask

  task automatic wreg(input byte_t a, input byte_t d);
    wr(a, 32'(d), 4'hf, rsp);
  endtask

  // Upper bytes and the response are checked on every register read
  task automatic rdc(input byte_t a, input byte_t e);
    rd(a, rv, rsp);
    chk(rv[7:0], e);
    chk(rv[31:24] | rv[23:16] | rv[15:8], 8'h00);
    chk(8'(rsp), 8'(`RESP_OKAY));
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  initial
  begin
    do_reset();
    chk(pu_en, 8'h00);
    ext_en <= 8'hff;
    ext_val <= 8'hff;
    rdc(`OFF_ADC, 8'h00);
    rdc(`OFF_PORT, 8'he0);
    rdc(`OFF_TRIS, 8'hff);
    rdc(`OFF_ICE, 8'hf5);
    rdc(`OFF_CFG, 8'h01);
    wr(`OFF_LAT, 32'h0000_0055, 4'he, rsp);
    rdc(`OFF_LAT, 8'h00);
    wreg(`OFF_CFG, 8'h00);
    rdc(`OFF_CFG, 8'h01);
    wr(8'h40, 32'h0000_00ff, 4'hf, rsp);
    chk(8'(rsp), 8'(`RESP_SLVERR));
    rd(8'h40, rv, rsp);
    chk(rv[7:0], 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      wreg(adr[i], 8'hff);
      rdc(adr[i], msk[i]);
    end
    for (int f = 0; f < 16; f++)
    begin
      wreg(`OFF_ADC, 8'(f));
      chk(8'(an_sel), 8'(exp_an(4'(f))));
    end
    c2_en <= 1'b1;
    for (int k = 0; k < 24; k++)
    begin
      rnd = lfsr(rnd);
      lat = rnd[7:0];
      tris = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : rnd[15:8];
      ext_val <= rnd[23:16];
      ext_en <= tris;
      c2_out <= rnd[26];
      wreg(`OFF_LAT, lat);
      wreg(`OFF_TRIS, tris);
      wreg(`OFF_ICE, {rnd[24], rnd[29:27], 3'h2, rnd[30]});
      wreg(`OFF_CTL, 8'(rnd[25]));
      repeat (3) @(posedge clk);
      lvl = (lat & ~tris) | (rnd[23:16] & tris);
      if (!tris[3])
        lvl[3] = rnd[26];
      chk(oe_n, tris);
      chk(pin_o & ~tris, lvl & ~tris);
      chk(pu_en, rnd[24] ? 8'h00 : tris);
      chk(8'(edg), 8'(rnd[29:27]));
      chk(8'(prio), 8'(rnd[30]));
      rdc(`OFF_LAT, lat);
      rdc(`OFF_PORT, lvl);
      chk(8'(irq_in), 8'(lvl[2:0]));
      chk(8'(flt), 8'(rnd[25] & tris[0] & lvl[0]));
      chk(8'(c2_in), 8'(tris[3] & lvl[3]));
    end
    wreg(`OFF_TRIS, 8'h00);
    wreg(`OFF_LAT, 8'h15);
    wreg(`OFF_ADC, 8'h00);
    chk(8'(an_sel), 8'h1f);
    chk(oe_n, 8'h00);
    chk(pin_o & 8'h17, 8'h15);
    ext_en <= 8'hff;
    ext_val <= 8'hff;
    wreg(`OFF_TRIS, 8'hff);
    repeat (3) @(posedge clk);
    rdc(`OFF_PORT, 8'he0);
    chk(8'(irq_in), 8'h00);
    wreg(`OFF_ADC, 8'h0f);
    wreg(`OFF_ICE, 8'h80);
    ext_val <= 8'h00;
    repeat (3) @(posedge clk);
    rd(`OFF_PORT, rv, rsp);
    wreg(`OFF_ICM, 8'h08);
    chk(8'(chg), 8'h00);
    ext_val <= 8'h04;
    repeat (3) @(posedge clk);
    chk(8'(chg), 8'h00);
    ext_val <= 8'h24;
    repeat (4) @(posedge clk);
    chk(8'(chg), 8'h01);
    wreg(`OFF_ICM, 8'h08);
    chk(8'(chg), 8'h01);
    rd(`OFF_PORT, rv, rsp);
    wreg(`OFF_ICM, 8'h08);
    chk(8'(chg), 8'h00);
    wreg(`OFF_TRIS, 8'hdf);
    repeat (3) @(posedge clk);
    chk(8'(chg), 8'h00);
    dbg <= 1'b1;
    pd_drv <= 1'b1;
    ext_en <= 8'h40;
    ext_val <= 8'h40;
    wreg(`OFF_LAT, 8'hff);
    wreg(`OFF_TRIS, 8'h00);
    repeat (3) @(posedge clk);
    chk(oe_n & 8'hc0, 8'h40);
    chk(pin_o & 8'h80, 8'h00);
    chk(8'(pc_in), 8'h01);
    pd_drv <= 1'b0;
    ext_en <= 8'hc0;
    ext_val <= 8'h80;
    repeat (3) @(posedge clk);
    chk(8'(pd_in), 8'h01);
    chk(8'(pc_in), 8'h00);
    dbg <= 1'b0;
    ad_cfg <= 1'b0;
    lvp_cfg <= 1'b1;
    cap_cfg <= 1'b1;
    do_reset();
    rdc(`OFF_ADC, 8'h07);
    rdc(`OFF_CFG, 8'h06);
    c2_out <= 1'b1;
    ext_en <= 8'h20;
    ext_val <= 8'h20;
    wreg(`OFF_LAT, 8'h00);
    wreg(`OFF_TRIS, 8'h00);
    repeat (3) @(posedge clk);
    chk(oe_n, 8'h20);
    chk(8'(pm_in), 8'h01);
    chk(pin_o & 8'h08, 8'h00);
    wrap_up();
  end
endmodule
